// *** rtl/timer_capture_and_compare.sv ***
// Function
// - each qualifying capture pin event latches the selected 16-bit timer into the queue unless it is full
// - capture timer select one picks timer_a, zero picks timer_b
// - captures held in a four-deep queue, read oldest first
// - interrupt after 1..4 captures per field code; ignored in every-edge mode
// - capture overflow flag read-only, cleared only by hardware
// - queue-not-empty flag is one while unread captures remain
// - mode 000 off, 110 disabled, 001 every edge, 010 falling, 011 rising
// - mode 100 captures every fourth rise, 101 every sixteenth rise
// - mode 111 is only a rising-edge interrupt source during sleep or idle
// - capture idle halt bit stops the capture channel in cpu idle
// - compare timer select one picks timer_b, zero picks timer_a
// - mode 001 starts low, match forces high, interrupt on rise
// - mode 010 starts high, match forces low, interrupt on fall
// - mode 011 keeps level, toggles per match, interrupt on both edges
// - mode 100 starts low, one pulse, interrupt on its fall
// - mode 101 starts low, continuous pulses, interrupt on each fall
// - pwm starts per primary value; 110 no interrupt, 111 fault interrupt
// - compare fault status set by pwm fault, cleared at timer zero with fault line high or by a control write
// - compare idle halt stops channel; mode 000 hands pin to gpio
`timescale 1ns/1ps
`default_nettype none

module timer_capture_and_compare #(
    parameter int TIMER_WIDTH = 16
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    // pins and time bases
    input wire capcmp_pkg::pins_in_s pins_in,
    input wire capcmp_pkg::timers_s timers_in,
    input wire logic gpio_level_in,
    // events and pin outputs
    output logic capture_irq_out,
    output logic compare_irq_out,
    output logic compare_output_pin_out,
    output logic compare_output_oe_out
);
    import capcmp_pkg::*;

    // capture control state
    logic cap_idle_ff, cap_tsel_ff, cap_ovf_ff;
    logic [1:0] cpi_ff;
    logic [2:0] cap_mode_ff;
    logic [TIMER_WIDTH-1:0] queue_ff [QUEUE_DEPTH];
    logic [1:0] wr_ptr_ff, rd_ptr_ff;
    logic [2:0] count_ff;
    logic [3:0] pre_ff;
    logic [1:0] cap_cnt_ff;
    logic pin_prev_ff;

    // compare control state
    logic cmp_idle_ff, cmp_tsel_ff, cmp_flt_ff;
    logic [2:0] cmp_mode_ff;
    logic [15:0] pri_ff, sec_ff;
    logic out_ff, fault_prev_ff;
    pulse_ph_e ph_ff;

    // capture qualification
    logic rise, fall, cap_run, cap_evt, pop, push;
    logic [TIMER_WIDTH-1:0] cap_time;
    logic cap_ctrl_wr, cmp_ctrl_wr;

    function automatic logic [1:0] ptr_inc(input logic [1:0] p);
        ptr_inc = p + 2'h1;
    endfunction

    assign rise = pins_in.capture_input_pin & ~pin_prev_ff;
    assign fall = ~pins_in.capture_input_pin & pin_prev_ff;
    assign cap_run = ~(cap_idle_ff & pins_in.cpu_idle);
    assign cap_time = cap_tsel_ff ? timers_in.timer_a[TIMER_WIDTH-1:0]
                                  : timers_in.timer_b[TIMER_WIDTH-1:0];
    assign cap_ctrl_wr = reg_wr_in && reg_addr_in == ADDR_CAP_CTRL;
    assign cmp_ctrl_wr = reg_wr_in && reg_addr_in == ADDR_CMP_CTRL;
    assign pop = reg_rd_in && reg_addr_in == ADDR_CAP_DATA && count_ff != 3'h0;

    // edge selection per capture mode
    always_comb
    begin
        cap_evt = 1'b0;
        case (cap_mode_ff)
            CAP_EVERY: cap_evt = rise | fall;
            CAP_FALL: cap_evt = fall;
            CAP_RISE: cap_evt = rise;
            CAP_RISE4: cap_evt = rise && pre_ff[1:0] == PRESCALE_4[1:0];
            CAP_RISE16: cap_evt = rise && pre_ff == PRESCALE_16;
            default: cap_evt = 1'b0; // off, unused and wake-only capture nothing
        endcase
        cap_evt = cap_evt & cap_run;
    end

    // a full queue drops the new value and flags overflow
    assign push = cap_evt && (count_ff != 3'(QUEUE_DEPTH) || pop);

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            pin_prev_ff <= 1'b0;
        else if (clk_en_in)
            pin_prev_ff <= pins_in.capture_input_pin;
    end

    // capture control register
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cap_idle_ff <= 1'b0;
            cap_tsel_ff <= 1'b0;
            cpi_ff <= 2'h0;
            cap_mode_ff <= CAP_OFF;
        end
        else if (clk_en_in && cap_ctrl_wr)
        begin
            cap_idle_ff <= reg_wdata_in[CAP_IDLE_BIT];
            cap_tsel_ff <= reg_wdata_in[CAP_TSEL_BIT];
            cpi_ff <= reg_wdata_in[CAP_CPI_LSB +: 2];
            cap_mode_ff <= reg_wdata_in[CAP_MODE_LSB +: 3];
        end
    end

    // prescaler counts rising edges; cleared on mode change
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            pre_ff <= 4'h0;
        else if (clk_en_in)
        begin
            if (cap_ctrl_wr)
                pre_ff <= 4'h0;
            else if (rise && cap_run)
                pre_ff <= pre_ff + 4'h1;
        end
    end

    // capture queue: turning the channel off empties it
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            wr_ptr_ff <= 2'h0;
            rd_ptr_ff <= 2'h0;
            count_ff <= 3'h0;
            cap_ovf_ff <= 1'b0;
            for (int i = 0; i < QUEUE_DEPTH; i++)
                queue_ff[i] <= '0;
        end
        else if (clk_en_in)
        begin
            if (cap_mode_ff == CAP_OFF)
            begin
                wr_ptr_ff <= 2'h0;
                rd_ptr_ff <= 2'h0;
                count_ff <= 3'h0;
                cap_ovf_ff <= 1'b0;
            end
            else
            begin
                if (push)
                begin
                    queue_ff[wr_ptr_ff] <= cap_time;
                    wr_ptr_ff <= ptr_inc(wr_ptr_ff);
                end
                if (pop)
                    rd_ptr_ff <= ptr_inc(rd_ptr_ff);
                count_ff <= count_ff + 3'(push) - 3'(pop);
                if (cap_evt && !push)
                    cap_ovf_ff <= 1'b1;
                else if (pop)
                    cap_ovf_ff <= 1'b0;
            end
        end
    end

    // capture interrupt counter and pulse
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cap_cnt_ff <= 2'h0;
            capture_irq_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            capture_irq_out <= 1'b0;
            if (cap_ctrl_wr)
                cap_cnt_ff <= 2'h0;
            else if (cap_mode_ff == CAP_WAKE)
                capture_irq_out <= rise && (pins_in.cpu_idle || pins_in.cpu_sleep);
            else if (cap_evt && cap_mode_ff == CAP_EVERY)
                capture_irq_out <= 1'b1;
            else if (cap_evt)
            begin
                if (cap_cnt_ff == cpi_ff)
                begin
                    cap_cnt_ff <= 2'h0;
                    capture_irq_out <= 1'b1;
                end
                else
                    cap_cnt_ff <= cap_cnt_ff + 2'h1;
            end
        end
    end

    // compare block
    logic cmp_run;
    logic [15:0] cmp_time;
    logic pri_hit, sec_hit, flt_fall, nxt_out, out_init;
    assign cmp_run = ~(cmp_idle_ff & pins_in.cpu_idle);
    assign cmp_time = cmp_tsel_ff ? timers_in.timer_b : timers_in.timer_a;
    assign pri_hit = cmp_run && cmp_time == pri_ff;
    assign sec_hit = cmp_run && cmp_time == sec_ff;
    assign flt_fall = ~pins_in.fault_input & fault_prev_ff;

    // entry level of the pin for a newly written mode
    always_comb
    begin
        case (reg_wdata_in[CMP_MODE_LSB +: 3])
            CMP_SET_LOW: out_init = 1'b1;
            CMP_OFF: out_init = gpio_level_in; // off keeps the gpio level
            CMP_TOGGLE: out_init = out_ff;
            CMP_PWM, CMP_PWM_FLT: out_init = pri_ff != 16'h0000;
            default: out_init = 1'b0;
        endcase
    end

    // compare control and value registers
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            cmp_idle_ff <= 1'b0;
            cmp_tsel_ff <= 1'b0;
            cmp_mode_ff <= CMP_OFF;
            pri_ff <= CMPVAL_RESET;
            sec_ff <= CMPVAL_RESET;
        end
        else if (clk_en_in && reg_wr_in)
        begin
            if (cmp_ctrl_wr)
            begin
                cmp_idle_ff <= reg_wdata_in[CMP_IDLE_BIT];
                cmp_tsel_ff <= reg_wdata_in[CMP_TSEL_BIT];
                cmp_mode_ff <= reg_wdata_in[CMP_MODE_LSB +: 3];
            end
            if (reg_addr_in == ADDR_CMP_PRI)
                pri_ff <= reg_wdata_in;
            if (reg_addr_in == ADDR_CMP_SEC)
                sec_ff <= reg_wdata_in;
        end
    end

    // next output level per mode
    always_comb
    begin
        nxt_out = out_ff;
        case (cmp_mode_ff)
            CMP_SET_HIGH: nxt_out = pri_hit ? 1'b1 : out_ff;
            CMP_SET_LOW: nxt_out = pri_hit ? 1'b0 : out_ff;
            CMP_TOGGLE: nxt_out = pri_hit ? ~out_ff : out_ff;
            CMP_PULSE, CMP_TRAIN:
            begin
                if (ph_ff == PH_WAIT_RISE && pri_hit)
                    nxt_out = 1'b1;
                else if (ph_ff == PH_WAIT_FALL && sec_hit)
                    nxt_out = 1'b0;
            end
            CMP_PWM, CMP_PWM_FLT:
            begin
                // high from period start until the duty match
                if (pri_hit)
                    nxt_out = 1'b0;
                else if (cmp_run && cmp_time == 16'h0000)
                    nxt_out = pri_ff != 16'h0000;
                if (cmp_mode_ff == CMP_PWM_FLT && (cmp_flt_ff || !pins_in.fault_input))
                    nxt_out = 1'b0; // fault parks the pin low
            end
            default: nxt_out = out_ff;
        endcase
    end

    // pin, pulse phase, fault and interrupt
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            out_ff <= 1'b0;
            ph_ff <= PH_WAIT_RISE;
            cmp_flt_ff <= 1'b0;
            fault_prev_ff <= 1'b1;
            compare_irq_out <= 1'b0;
            compare_output_pin_out <= 1'b0;
            compare_output_oe_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            fault_prev_ff <= pins_in.fault_input;
            compare_irq_out <= 1'b0;
            if (cmp_ctrl_wr)
            begin
                out_ff <= out_init;
                compare_output_oe_out <= reg_wdata_in[CMP_MODE_LSB +: 3] != CMP_OFF;
                compare_output_pin_out <= out_init;
                ph_ff <= PH_WAIT_RISE;
                cmp_flt_ff <= 1'b0;
            end
            else
            begin
                out_ff <= nxt_out;
                compare_output_oe_out <= cmp_mode_ff != CMP_OFF;
                compare_output_pin_out <= (cmp_mode_ff == CMP_OFF) ? gpio_level_in
                                                                   : nxt_out;
                case (cmp_mode_ff)
                    CMP_SET_HIGH: compare_irq_out <= nxt_out & ~out_ff;
                    CMP_SET_LOW: compare_irq_out <= ~nxt_out & out_ff;
                    CMP_TOGGLE: compare_irq_out <= nxt_out ^ out_ff;
                    CMP_PULSE, CMP_TRAIN:
                    begin
                        compare_irq_out <= ~nxt_out & out_ff;
                        if (ph_ff == PH_WAIT_RISE && nxt_out)
                            ph_ff <= PH_WAIT_FALL;
                        else if (ph_ff == PH_WAIT_FALL && !nxt_out)
                            ph_ff <= (cmp_mode_ff == CMP_TRAIN) ? PH_WAIT_RISE : PH_DONE;
                    end
                    CMP_PWM_FLT:
                    begin
                        if (flt_fall)
                        begin
                            cmp_flt_ff <= 1'b1;
                            compare_irq_out <= 1'b1;
                        end
                        else if (pins_in.fault_input && cmp_run && cmp_time == 16'h0000)
                            cmp_flt_ff <= 1'b0;
                    end
                    default: compare_irq_out <= 1'b0; // pwm without fault is silent
                endcase
            end
        end
    end

    // read data, valid in the cycle after the strobe
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
            reg_rdata_out <= 16'h0000;
        else if (clk_en_in)
        begin
            reg_rdata_out <= 16'h0000;
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    ADDR_CAP_CTRL:
                    begin
                        reg_rdata_out[CAP_IDLE_BIT] <= cap_idle_ff;
                        reg_rdata_out[CAP_TSEL_BIT] <= cap_tsel_ff;
                        reg_rdata_out[CAP_CPI_LSB +: 2] <= cpi_ff;
                        reg_rdata_out[CAP_OVF_BIT] <= cap_ovf_ff;
                        reg_rdata_out[CAP_NE_BIT] <= count_ff != 3'h0;
                        reg_rdata_out[CAP_MODE_LSB +: 3] <= cap_mode_ff;
                    end
                    ADDR_CAP_DATA: reg_rdata_out <= 16'(queue_ff[rd_ptr_ff]);
                    ADDR_CMP_CTRL:
                    begin
                        reg_rdata_out[CMP_IDLE_BIT] <= cmp_idle_ff;
                        reg_rdata_out[CMP_FLT_BIT] <= cmp_flt_ff;
                        reg_rdata_out[CMP_TSEL_BIT] <= cmp_tsel_ff;
                        reg_rdata_out[CMP_MODE_LSB +: 3] <= cmp_mode_ff;
                    end
                    ADDR_CMP_PRI: reg_rdata_out <= pri_ff;
                    ADDR_CMP_SEC: reg_rdata_out <= sec_ff;
                    default: reg_rdata_out <= 16'h0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// *** rtl/capcmp_pkg.sv ***
package capcmp_pkg;

    // register indices on the plain port
    localparam logic [3:0] ADDR_CAP_CTRL = 4'h0;
    localparam logic [3:0] ADDR_CAP_DATA = 4'h1;
    localparam logic [3:0] ADDR_CMP_CTRL = 4'h2;
    localparam logic [3:0] ADDR_CMP_PRI = 4'h3;
    localparam logic [3:0] ADDR_CMP_SEC = 4'h4;

    // capture control field positions
    localparam int CAP_IDLE_BIT = 13;
    localparam int CAP_TSEL_BIT = 7;
    localparam int CAP_CPI_LSB = 5;
    localparam int CAP_OVF_BIT = 4;
    localparam int CAP_NE_BIT = 3;
    localparam int CAP_MODE_LSB = 0;

    // compare control field positions
    localparam int CMP_IDLE_BIT = 13;
    localparam int CMP_FLT_BIT = 4;
    localparam int CMP_TSEL_BIT = 3;
    localparam int CMP_MODE_LSB = 0;

    // reset values
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [15:0] CMPVAL_RESET = 16'h0000;

    // queue and prescale counts
    localparam int QUEUE_DEPTH = 4;
    localparam logic [3:0] PRESCALE_4 = 4'h3;
    localparam logic [3:0] PRESCALE_16 = 4'hf;

    // capture modes
    localparam logic [2:0] CAP_OFF = 3'h0;
    localparam logic [2:0] CAP_EVERY = 3'h1;
    localparam logic [2:0] CAP_FALL = 3'h2;
    localparam logic [2:0] CAP_RISE = 3'h3;
    localparam logic [2:0] CAP_RISE4 = 3'h4;
    localparam logic [2:0] CAP_RISE16 = 3'h5;
    localparam logic [2:0] CAP_UNUSED = 3'h6;
    localparam logic [2:0] CAP_WAKE = 3'h7;

    // compare modes
    localparam logic [2:0] CMP_OFF = 3'h0;
    localparam logic [2:0] CMP_SET_HIGH = 3'h1;
    localparam logic [2:0] CMP_SET_LOW = 3'h2;
    localparam logic [2:0] CMP_TOGGLE = 3'h3;
    localparam logic [2:0] CMP_PULSE = 3'h4;
    localparam logic [2:0] CMP_TRAIN = 3'h5;
    localparam logic [2:0] CMP_PWM = 3'h6;
    localparam logic [2:0] CMP_PWM_FLT = 3'h7;

    // pin side signals that travel together
    typedef struct packed {
        logic capture_input_pin;
        logic fault_input;
        logic cpu_idle;
        logic cpu_sleep;
    } pins_in_s;

    typedef struct packed {
        logic [15:0] timer_a;
        logic [15:0] timer_b;
    } timers_s;

    // compare pulse sequencing
    typedef enum logic [1:0] {PH_WAIT_RISE, PH_WAIT_FALL, PH_DONE} pulse_ph_e;

endpackage

// *** testbench/capcmp_props.sv ***
`timescale 1ns/1ps
`default_nettype none

module capcmp_props (
    // clock and control
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic clk_en_in,
    // register port
    input wire logic [3:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    // pins and events
    input wire capcmp_pkg::pins_in_s pins_in,
    input wire logic gpio_level_in,
    input wire logic capture_irq_out,
    input wire logic compare_irq_out,
    input wire logic compare_output_pin_out,
    input wire logic compare_output_oe_out
);
    import capcmp_pkg::*;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // outputs quiet out of reset
    chk_reset_quiet:
    assert property ($fell(sys_rst_in) |-> !capture_irq_out && !compare_irq_out
        && !compare_output_pin_out && !compare_output_oe_out && reg_rdata_out == 16'h0000)
        else $error("outputs not low after reset");
    // read data only after a read strobe
    chk_rd_quiet:
    assert property ($past(clk_en_in) && !$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data without a read");
    // unmapped reads zero
    chk_unmapped_zero:
    assert property ($past(clk_en_in && reg_rd_in) && $past(reg_addr_in) > ADDR_CMP_SEC
        |-> reg_rdata_out == 16'h0000) else $error("unmapped index read nonzero");
    // reserved compare bits read zero
    chk_cmp_resv:
    assert property ($past(clk_en_in && reg_rd_in && reg_addr_in == ADDR_CMP_CTRL)
        |-> reg_rdata_out[15:14] == 2'h0 && reg_rdata_out[12:5] == 8'h00)
        else $error("compare control reserved bits set");
    // a low enable freezes the pin side
    chk_freeze_hold:
    assert property (!$past(clk_en_in) |-> $stable(compare_output_pin_out)
        && $stable(compare_output_oe_out) && $stable(reg_rdata_out))
        else $error("outputs moved while frozen");
    // a capture irq needs a pin edge
    chk_cap_edge:
    assert property ($rose(capture_irq_out) |-> $past(pins_in.capture_input_pin)
        != $past(pins_in.capture_input_pin, 2)) else $error("capture irq without pin edge");
    // fault line high: a compare event moves the pin
    chk_cmp_edge:
    assert property ($rose(compare_irq_out) && pins_in.fault_input && $past(pins_in.fault_input)
        && $past(pins_in.fault_input, 2) |-> $changed(compare_output_pin_out))
        else $error("compare irq without pin edge");
    // disabled channel passes the gpio level
    chk_gpio_follow:
    assert property (!compare_output_oe_out && !$past(compare_output_oe_out) && $past(clk_en_in)
        && !$past(sys_rst_in) && !$past(sys_rst_in, 2)
        |-> compare_output_pin_out == $past(gpio_level_in)) else $error("pin ignores gpio");
    // oe moves only on a compare control write
    chk_oe_hold:
    assert property ($past(clk_en_in) && !$past(reg_wr_in && reg_addr_in == ADDR_CMP_CTRL)
        |-> $stable(compare_output_oe_out)) else $error("oe moved without a write");
endmodule

bind timer_capture_and_compare capcmp_props capcmp_props_inst (.clk_in, .sys_rst_in,
    .clk_en_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .pins_in,
    .gpio_level_in, .capture_irq_out, .compare_irq_out, .compare_output_pin_out,
    .compare_output_oe_out);

`default_nettype wire

// *** testbench/pin_side_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module pin_side_model (
    // bench controls
    input wire logic clk_in,
    input wire logic run_in,
    input wire logic clr_in,
    input wire logic cap_level_in,
    input wire logic fault_n_in,
    input wire logic idle_in,
    input wire logic sleep_in,
    // levels seen by the block
    output var capcmp_pkg::pins_in_s pins_out,
    output var capcmp_pkg::timers_s timers_out
);
    import capcmp_pkg::*;

    logic [15:0] count_ff;

    // shared count; holds while stopped for safe compare setup
    always_ff @(posedge clk_in)
    begin
        if (clr_in)
            count_ff <= 16'h0000;
        else if (run_in)
            count_ff <= count_ff + 16'h0001;
    end

    // second base scrambled so a wrong select shows
    assign timers_out = {count_ff, count_ff ^ 16'h5a5a};
    assign pins_out = {cap_level_in, fault_n_in, idle_in, sleep_in};
endmodule

`default_nettype wire

// *** testbench/timer_capture_and_compare_bench.sv ***
`timescale 1ns/1ps
`default_nettype none

module timer_capture_and_compare_bench;
    import capcmp_pkg::*;

    logic clk = 1'b0, wr = 1'b0, rd = 1'b0, gpio = 1'b0, run = 1'b0, cap = 1'b0;
    logic rst = 1'b1, en = 1'b1, clr = 1'b1, flt_n = 1'b1, idle = 1'b0, sleep = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic [15:0] rdata;
    pins_in_s pins;
    timers_s tims;
    logic irq_c, irq_k, pin, oe, pin_d;
    int fail_count = 0;
    int tests_run = 0;
    int n_ci = 0, n_ki = 0, n_pe = 0;
    logic [15:0] expq[$];

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    timer_capture_and_compare timer_capture_and_compare_inst (
        .clk_in(clk), .sys_rst_in(rst), .clk_en_in(en), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .pins_in(pins), .timers_in(tims), .gpio_level_in(gpio), .capture_irq_out(irq_c),
        .compare_irq_out(irq_k), .compare_output_pin_out(pin), .compare_output_oe_out(oe));

    pin_side_model pin_side_model_inst (.clk_in(clk), .run_in(run), .clr_in(clr),
        .cap_level_in(cap), .fault_n_in(flt_n), .idle_in(idle), .sleep_in(sleep),
        .pins_out(pins), .timers_out(tims));

    // running tallies, never cleared
    always @(posedge clk)
    begin
        pin_d <= pin;
        if (irq_c === 1'b1) n_ci++;
        if (irq_k === 1'b1) n_ki++;
        if (pin !== pin_d) n_pe++;
    end

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // data stand one cycle after the strobe edge
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic reg_tests();
        logic [15:0] d;
        for (int a = 0; a < 16; a++)
        begin
            if (a != 1)
            begin
                rd_reg(4'(a), d);
                chk16(d, CTRL_RESET);
            end
        end
        wr_reg(4'hf, 16'hffff);
        rd_reg(4'hf, d);
        chk16(d, 16'h0000);
        wr_reg(ADDR_CAP_CTRL, 16'hffff);
        rd_reg(ADDR_CAP_CTRL, d);
        chk16(d, 16'h20e7);
        wr_reg(ADDR_CMP_CTRL, 16'hffff);
        rd_reg(ADDR_CMP_CTRL, d);
        chk16(d, 16'h200f);
        wr_reg(ADDR_CMP_PRI, 16'h1234);
        rd_reg(ADDR_CMP_PRI, d);
        chk16(d, 16'h1234);
        wr_reg(ADDR_CAP_CTRL, CTRL_RESET);
        wr_reg(ADDR_CMP_CTRL, CTRL_RESET);
    endtask

    // cfg: capture control word; pin toggles every third cycle
    task automatic cap_run(input logic [15:0] cfg, input int ntog);
        int rises = 0, caps = 0, c0;
        logic [15:0] d;
        logic [2:0] m;
        logic hit;
        m = cfg[2:0];
        expq.delete();
        wr_reg(ADDR_CAP_CTRL, CTRL_RESET);
        wr_reg(ADDR_CAP_CTRL, cfg);
        c0 = n_ci;
        for (int i = 0; i < ntog; i++)
        begin
            @(posedge clk);
            cap <= ~cap;
            #1;
            rises += cap;
            hit = !(cfg[CAP_IDLE_BIT] && idle) && ((m == CAP_EVERY) || (m == CAP_FALL && !cap)
                || (m == CAP_RISE && cap) || (m == CAP_RISE4 && cap && rises % 4 == 0)
                || (m == CAP_RISE16 && cap && rises % 16 == 0));
            caps += hit;
            if (hit && expq.size() < QUEUE_DEPTH)
                expq.push_back(cfg[CAP_TSEL_BIT] ? tims.timer_a : tims.timer_b);
            repeat (2) @(posedge clk);
        end
        #1;
        if (m == CAP_WAKE)
            chk16(16'(n_ci - c0), (idle | sleep) ? 16'(rises) : 16'h0000);
        else if (caps <= QUEUE_DEPTH)
            chk16(16'(n_ci - c0), 16'(m == CAP_EVERY ? caps : caps / (int'(cfg[6:5]) + 1)));
        rd_reg(ADDR_CAP_CTRL, d);
        chk16(16'(d[CAP_OVF_BIT]), 16'(caps > QUEUE_DEPTH));
        foreach (expq[i])
        begin
            rd_reg(ADDR_CAP_CTRL, d);
            chk16(16'(d[CAP_NE_BIT]), 16'h0001);
            rd_reg(ADDR_CAP_DATA, d);
            chk16(d, expq[i]);
        end
        rd_reg(ADDR_CAP_CTRL, d);
        chk16(d, cfg);
    endtask

    // timer stopped and zeroed for setup; secondary is ten above
    task automatic cmp_run(input logic [15:0] cfg, input logic [15:0] pri, input int ent,
        input int edges, input int irqs, input logic fin);
        int p0, i0;
        @(posedge clk);
        run <= 1'b0;
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        wr_reg(ADDR_CMP_PRI, pri);
        wr_reg(ADDR_CMP_SEC, pri + 16'h000a);
        wr_reg(ADDR_CMP_CTRL, cfg);
        repeat (2) @(posedge clk);
        #1;
        chk16(16'(pin), 16'(ent));
        p0 = n_pe;
        i0 = n_ki;
        @(posedge clk);
        run <= 1'b1;
        repeat (40) @(posedge clk);
        run <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk16(16'(n_pe - p0), 16'(edges));
        chk16(16'(n_ki - i0), 16'(irqs));
        chk16(16'(pin), 16'(fin));
    endtask

    task automatic cap_tests();
        cap_run(16'h0083, 8);
        cap_run(16'h0003, 12);
        cap_run(16'h0002, 6);
        cap_run(16'h0061, 4);
        cap_run(16'h0023, 8);
        cap_run(16'h0043, 6);
        cap_run(16'h0063, 8);
        cap_run(16'h0004, 32);
        cap_run(16'h0005, 32);
        cap_run(16'h0006, 8);
        cap_run(16'h0007, 4);
        @(posedge clk) idle <= 1'b1;
        cap_run(16'h2003, 4);
        cap_run(16'h0003, 4);
        cap_run(16'h0007, 4);
        @(posedge clk) idle <= 1'b0;
    endtask

    task automatic cmp_tests();
        logic [15:0] d;
        int k0;
        cmp_run(16'h0001, 16'h000a, 0, 1, 1, 1);
        cmp_run(16'h0002, 16'h000a, 1, 1, 1, 0);
        cmp_run(16'h0003, 16'h000a, 0, 1, 1, 1);
        cmp_run(16'h0003, 16'h000a, 1, 1, 1, 0);
        cmp_run(16'h0004, 16'h000a, 0, 2, 1, 0);
        cmp_run(16'h0005, 16'h000a, 0, 2, 1, 0);
        cmp_run(16'h0006, 16'h000a, 1, 1, 0, 0);
        cmp_run(16'h0006, 16'h0000, 0, 0, 0, 0);
        cmp_run(16'h0009, 16'h5a50, 0, 1, 1, 1);
        cmp_run(16'h0001, 16'h5a50, 0, 0, 0, 0);
        @(posedge clk) idle <= 1'b1;
        cmp_run(16'h2001, 16'h000a, 0, 0, 0, 0);
        cmp_run(16'h0001, 16'h000a, 0, 1, 1, 1);
        @(posedge clk) idle <= 1'b0;
        @(posedge clk) gpio <= 1'b1;
        wr_reg(ADDR_CMP_CTRL, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        chk16({14'h0, oe, pin}, 16'h0001);
        @(posedge clk);
        en <= 1'b0;
        gpio <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        chk16(16'(pin), 16'h0001);
        @(posedge clk) en <= 1'b1;
        cmp_run(16'h0007, 16'h000a, 1, 1, 0, 0);
        // fault bit drops only at timer zero, line high
        k0 = n_ki;
        @(posedge clk) flt_n <= 1'b0;
        repeat (6) @(posedge clk);
        rd_reg(ADDR_CMP_CTRL, d);
        chk16(d, 16'h0017);
        chk16(16'(n_ki - k0), 16'h0001);
        @(posedge clk) flt_n <= 1'b1;
        rd_reg(ADDR_CMP_CTRL, d);
        chk16(d, 16'h0017);
        @(posedge clk) clr <= 1'b1;
        repeat (3) @(posedge clk);
        clr <= 1'b0;
        rd_reg(ADDR_CMP_CTRL, d);
        chk16(d, 16'h0007);
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        clr <= 1'b0;
        reg_tests();
        cap_tests();
        cmp_tests();
        report_and_stop();
    end

    // about 1.5k cycles needed
    initial
    begin
        #200000;
        fail_count++;
        report_and_stop();
    end
endmodule

`default_nettype wire
